// ### rtl/hmw_pkg.sv
/*
  Shared constants and types for the halfword-to-word multiply-accumulate
  datapath: register offsets, field positions, reset values and the
  packed carriers that travel between the datapath files.
  Assumes a single 100 MHz core clock and a synchronous active-high reset.
*/
package hmw_pkg;

  // Datapath widths
  localparam int HALF_W = 16;
  localparam int WORD_W = 32;
  localparam int SUM_W  = 33;

  // Register offsets on the plain register port
  localparam logic [3:0] REG_EXC    = 4'h0;
  localparam logic [3:0] REG_COND   = 4'h4;
  localparam logic [3:0] REG_RESULT = 4'h8;
  localparam logic [3:0] REG_COUNT  = 4'hC;

  // Summary and overflow positions inside the exception register word
  localparam int EXC_SO_POS = 31;
  localparam int EXC_OVF_POS = 30;

  // Condition field zero: less, greater, equal, summary copy
  localparam int CR_LT_POS = 3;
  localparam int CR_GT_POS = 2;
  localparam int CR_EQ_POS = 1;
  localparam int CR_SO_POS = 0;

  // Reset values
  localparam logic [31:0] WORD_RST  = 32'h0000_0000;
  localparam logic [3:0]  COND_RST  = 4'h0;
  localparam logic        FLAG_RST  = 1'b0;

  // Saturation limits
  localparam logic [31:0] U_MAX = 32'hFFFF_FFFF;
  localparam logic [31:0] S_MAX = 32'h7FFF_FFFF;
  localparam logic [31:0] S_MIN = 32'h8000_0000;

  // Instruction variant selected by the issuing pipeline
  typedef struct packed {
    logic highHalf;   // Operand bits 0:15 when set, 16:31 when clear
    logic isSigned;   // Signed product and accumulate
    logic saturate;   // Clamp on overflow instead of wrapping
    logic recordEn;   // Trailing-period form: write condition field
    logic ovEnable;   // Overflow-enabled form: write exception bits
  } hmw_op_t;

  // Clamp stage answer
  typedef struct packed {
    logic [31:0] word;
    logic        ovf;
  } hmw_res_t;

  // Whole state of the datapath top
  typedef struct packed {
    logic        resValid;
    logic [31:0] resData;
    logic        cr0Wr;
    logic [3:0]  cr0;
    logic        xerWr;
    logic        ovFlag;
    logic        soFlag;
    logic [31:0] rdData;
    logic [31:0] opCount;
  } hmw_state_t;

endpackage

// ### rtl/hmw_sat_clamp.sv
/*
  Overflow detection and saturation of the 33-bit accumulate sum.
  Purely combinational; the caller registers its answer.
*/
`timescale 1ns/1ps
`default_nettype none

module hmw_sat_clamp (
  // Sum and variant
  input  wire logic [32:0]       sum,
  input  wire logic              isSigned,
  input  wire logic              saturate,
  // Answer
  output hmw_pkg::hmw_res_t      res
);

  logic ovf;

  // Signed sums overflow when bit 32 and bit 31 disagree
  assign ovf = isSigned ? (sum[32] ^ sum[31]) : sum[32];

  // Bit 32 carries the sign of the true sum, so it picks the signed limit
  always_comb begin
    res.ovf  = ovf;
    res.word = sum[31:0];
    if (saturate && ovf) begin
      if (!isSigned) begin
        res.word = hmw_pkg::U_MAX;
      end else if (sum[32]) begin
        res.word = hmw_pkg::S_MIN;
      end else begin
        res.word = hmw_pkg::S_MAX;
      end
    end
  end

endmodule

`default_nettype wire

// ### rtl/hmw_mac_top.sv
/*
  Halfword-to-word multiply-accumulate datapath with its exception and
  condition bits and a small register port for software.
  Assumes the issuing pipeline presents one operation per opValid cycle
  together with the current destination value, and that register strobes
  are one cycle long and never coincide.
*/
`timescale 1ns/1ps
`default_nettype none

module hmw_mac_top (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Operation issue
  input  wire logic              opValid,
  input  wire hmw_pkg::hmw_op_t  opCtl,
  input  wire logic [31:0]       srcFirstReg,
  input  wire logic [31:0]       srcSecondReg,
  input  wire logic [31:0]       dstIn,
  // Destination write-back
  output logic                   resValid,
  output logic [31:0]            resData,
  // Condition field zero
  output logic                   cr0Wr,
  output logic [3:0]             condFieldZero,
  // Fixed-point exception bits
  output logic                   xerWr,
  output logic                   overflowFlag,
  output logic                   summaryFlag,
  // Register port
  input  wire logic [3:0]        regAddr,
  input  wire logic [31:0]       regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic [31:0]            regRdData
);

  hmw_pkg::hmw_state_t st_ff;
  hmw_pkg::hmw_state_t nxt_st;

  logic [15:0]        halfA;
  logic [15:0]        halfB;
  logic signed [16:0] extA;
  logic signed [16:0] extB;
  logic signed [33:0] prodWide;
  logic [31:0]        product;
  logic               prodExt;
  logic               dstExt;
  logic [32:0]        sum33;
  hmw_pkg::hmw_res_t  clampRes;
  logic               ovBase;
  logic               soBase;
  logic               soAfter;
  logic [3:0]         cr0Calc;

  // Operand selection: bits 0:15 are the upper half in this numbering
  always_comb begin
    if (opCtl.highHalf) begin
      halfA = srcFirstReg[31:16];
      halfB = srcSecondReg[31:16];
    end else begin
      halfA = srcFirstReg[15:0];
      halfB = srcSecondReg[15:0];
    end
  end

  // A 17-bit extension makes one signed multiplier serve both kinds
  assign extA = $signed({opCtl.isSigned & halfA[15], halfA});
  assign extB = $signed({opCtl.isSigned & halfB[15], halfB});
  assign prodWide = extA * extB;

  // Either product fits in 32 bits: 65535 squared and -32768 squared do
  assign product = prodWide[31:0];

  // Extend both addends to 33 bits so the carry or sign survives
  assign prodExt = opCtl.isSigned & product[31];
  assign dstExt  = opCtl.isSigned & dstIn[31];
  assign sum33   = {prodExt, product} + {dstExt, dstIn};

  // Overflow check and clamping
  hmw_sat_clamp u_clamp (
    .sum      (sum33),
    .isSigned (opCtl.isSigned),
    .saturate (opCtl.saturate),
    .res      (clampRes)
  );

  // Exception bits as left by a software write in this cycle
  always_comb begin
    ovBase = st_ff.ovFlag;
    soBase = st_ff.soFlag;
    if (regWr && regAddr == hmw_pkg::REG_EXC) begin
      ovBase = regWrData[hmw_pkg::EXC_OVF_POS];
      soBase = regWrData[hmw_pkg::EXC_SO_POS];
    end
  end

  // Summary after this operation, seen by the condition field too
  always_comb begin
    soAfter = soBase;
    if (opValid && opCtl.ovEnable) begin
      soAfter = soBase | clampRes.ovf;
    end
  end

  // Condition field compares the written word as a signed value
  always_comb begin
    cr0Calc = hmw_pkg::COND_RST;
    cr0Calc[hmw_pkg::CR_LT_POS] = clampRes.word[31];
    cr0Calc[hmw_pkg::CR_GT_POS] = ~clampRes.word[31]
                                  & (|clampRes.word[30:0]);
    cr0Calc[hmw_pkg::CR_EQ_POS] = ~(|clampRes.word);
    cr0Calc[hmw_pkg::CR_SO_POS] = soAfter;
  end

  // Next state: an overflow-enabled operation in the same cycle as a software write of
  // the exception bits wins, so no hardware overflow is ever lost
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.resValid = opValid;
    nxt_st.cr0Wr    = 1'b0;
    nxt_st.xerWr    = 1'b0;
    nxt_st.rdData   = hmw_pkg::WORD_RST;
    nxt_st.ovFlag   = ovBase;
    nxt_st.soFlag   = soBase;

    // Software clears the operation counter by writing it
    if (regWr && regAddr == hmw_pkg::REG_COUNT) begin
      nxt_st.opCount = hmw_pkg::WORD_RST;
    end

    if (opValid) begin
      // Clamped word for saturating overflow, low word otherwise
      nxt_st.resData = clampRes.word;
      nxt_st.opCount = nxt_st.opCount + 32'h0000_0001;

      // Base form touches neither bit group
      if (opCtl.ovEnable) begin
        nxt_st.xerWr  = 1'b1;
        nxt_st.ovFlag = clampRes.ovf;
        nxt_st.soFlag = soAfter;
      end
      if (opCtl.recordEn) begin
        nxt_st.cr0Wr = 1'b1;
        nxt_st.cr0   = cr0Calc;
      end
    end

    // Reads see the state before this cycle's updates
    if (regRd) begin
      case (regAddr)
        hmw_pkg::REG_EXC: begin
          nxt_st.rdData[hmw_pkg::EXC_OVF_POS] = st_ff.ovFlag;
          nxt_st.rdData[hmw_pkg::EXC_SO_POS] = st_ff.soFlag;
        end
        hmw_pkg::REG_COND: begin
          nxt_st.rdData[3:0] = st_ff.cr0;
        end
        hmw_pkg::REG_RESULT: begin
          nxt_st.rdData = st_ff.resData;
        end
        hmw_pkg::REG_COUNT: begin
          nxt_st.rdData = st_ff.opCount;
        end
        default: begin
          nxt_st.rdData = hmw_pkg::WORD_RST;  // Unmapped reads as zero
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff.resValid <= 1'b0;
      st_ff.resData  <= hmw_pkg::WORD_RST;
      st_ff.cr0Wr    <= 1'b0;
      st_ff.cr0      <= hmw_pkg::COND_RST;
      st_ff.xerWr    <= 1'b0;
      st_ff.ovFlag   <= hmw_pkg::FLAG_RST;
      st_ff.soFlag   <= hmw_pkg::FLAG_RST;
      st_ff.rdData   <= hmw_pkg::WORD_RST;
      st_ff.opCount  <= hmw_pkg::WORD_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign resValid      = st_ff.resValid;
  assign resData       = st_ff.resData;
  assign cr0Wr         = st_ff.cr0Wr;
  assign condFieldZero = st_ff.cr0;
  assign xerWr         = st_ff.xerWr;
  assign overflowFlag  = st_ff.ovFlag;
  assign summaryFlag   = st_ff.soFlag;
  assign regRdData     = st_ff.rdData;

endmodule

`default_nettype wire

// ### verif/hmw_mac_checker.sv
/* Port assertions for the multiply-accumulate top.
   Bound to hmw_mac_top from the testbench top file. */
`timescale 1ns/1ps
`default_nettype none
module hmw_mac_checker (
  // Clock, reset and issue
  input wire logic             clk,
  input wire logic             srst,
  input wire logic             opValid,
  input wire hmw_pkg::hmw_op_t opCtl,
  // Results and flags
  input wire logic             resValid,
  input wire logic [31:0]      resData,
  input wire logic             cr0Wr,
  input wire logic [3:0]       condFieldZero,
  input wire logic             xerWr,
  input wire logic             overflowFlag,
  input wire logic             summaryFlag,
  // Register port
  input wire logic [3:0]       regAddr,
  input wire logic             regWr,
  input wire logic             regRd,
  input wire logic [31:0]      regRdData
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Issue and its answer one cycle on
  sequence s_issue;
    opValid ##1 resValid;
  endsequence
  // Software write to the exception word may also move the flags
  sequence s_base;
    opValid && !opCtl.ovEnable && !(regWr && regAddr == 4'h0);
  endsequence
  a_answer_next: assert property (opValid |-> s_issue)
    else $error("no result one cycle after issue");
  a_no_spurious: assert property (!opValid |=>
    !resValid && !cr0Wr && !xerWr)
    else $error("result pulse without issue");
  a_record_gate: assert property (
    opValid |=> cr0Wr == $past(opCtl.recordEn))
    else $error("condition write does not follow record form");
  a_ov_gate: assert property (
    opValid |=> xerWr == $past(opCtl.ovEnable))
    else $error("exception write does not follow overflow form");
  a_base_flags: assert property (
    s_base |=> $stable({overflowFlag, summaryFlag}))
    else $error("flags moved on a form without overflow enable");
  a_cond_hold: assert property (
    opValid && !opCtl.recordEn |=> $stable(condFieldZero))
    else $error("condition field moved on a form without record");
  a_so_covers: assert property (
    xerWr && overflowFlag |-> summaryFlag)
    else $error("summary clear while overflow set");
  a_so_sticky: assert property (
    summaryFlag && !(regWr && regAddr == 4'h0) |=> summaryFlag)
    else $error("summary cleared without software write");
  a_cond_sign: assert property (cr0Wr |->
    condFieldZero[3:1] == {resData[31],
    !resData[31] && resData != 32'h0, resData == 32'h0})
    else $error("condition field does not match result");
  a_rd_idle: assert property (!regRd |=> regRdData == 32'h0)
    else $error("read data without read strobe");
endmodule
`default_nettype wire

// ### verif/hmw_mac_top_test.sv
/* Self-checking bench for the multiply-accumulate top.
   Assumes hmw_pkg and hmw_mac_checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module hmw_mac_top_test;
  logic             clk = 1'b0, srst = 1'b1, opValid = 1'b0;
  hmw_pkg::hmw_op_t opCtl = '0, pc = '0;
  logic [31:0]      srcFirstReg = 32'h0, srcSecondReg = 32'h0, dstIn = 32'h0;
  logic [31:0]      regWrData = 32'h0, resData, regRdData, eRes = 32'h0;
  logic [3:0]       regAddr = 4'h0, condFieldZero, eCr = 4'h0;
  logic             regWr = 1'b0, regRd = 1'b0, resValid, cr0Wr, xerWr;
  logic             overflowFlag, summaryFlag, pv = 1'b0;
  logic             eOv = 1'b0, eSo = 1'b0;
  int               errors = 0, tests_run = 0, cycles = 0;
  hmw_mac_top dut (.clk, .srst, .opValid, .opCtl, .srcFirstReg, .srcSecondReg,
    .dstIn, .resValid, .resData, .cr0Wr, .condFieldZero, .xerWr, .overflowFlag,
    .summaryFlag, .regAddr, .regWrData, .regWr, .regRd, .regRdData);
  always #5 clk = ~clk;
  // Hang guard: all tests need well under 300 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      errors++;
      give_verdict();
    end
  end
  task chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Reference: {overflow, written word}; ifs keep signedness unmixed
  function automatic logic [32:0] mac(hmw_pkg::hmw_op_t c, logic [31:0] a, b, d);
    logic [15:0] x, y;
    logic [31:0] p;
    logic [32:0] s;
    logic        ov;
    x = c.highHalf ? a[31:16] : a[15:0];
    y = c.highHalf ? b[31:16] : b[15:0];
    if (c.isSigned) p = $signed(x) * $signed(y);
    else p = x * y;
    if (c.isSigned) s = {p[31], p} + {d[31], d};
    else s = {1'b0, p} + {1'b0, d};
    ov = c.isSigned ? s[32] ^ s[31] : s[32];
    if (c.saturate && ov && !c.isSigned) begin
      return {1'b1, hmw_pkg::U_MAX};
    end
    if (c.saturate && ov) begin
      return {1'b1, s[32] ? hmw_pkg::S_MIN : hmw_pkg::S_MAX};
    end
    return {ov, s[31:0]};
  endfunction
  // Issue one op (or idle) and judge the op issued one edge earlier
  task step(input logic v, input hmw_pkg::hmw_op_t c, input logic [31:0] a, b, d);
    logic [32:0] m;
    @(posedge clk);
    opValid <= v;
    opCtl <= c;
    srcFirstReg <= a;
    srcSecondReg <= b;
    dstIn <= d;
    #1;
    chk(resValid, pv);
    chk(cr0Wr, pv & pc.recordEn);
    chk(xerWr, pv & pc.ovEnable);
    if (pv) chk(resData, eRes);
    chk({overflowFlag, summaryFlag}, {eOv, eSo});
    chk(condFieldZero, eCr);
    m = mac(c, a, b, d);
    pv = v;
    pc = c;
    if (v && c.ovEnable) {eOv, eSo} = {m[32], eSo | m[32]};
    if (v) eRes = m[31:0];
    if (v && c.recordEn) eCr = {$signed(eRes) < 0, $signed(eRes) > 0, eRes == 0, eSo};
  endtask
  task reg_io(input logic w, r, input logic [3:0] adr, input logic [31:0] wd, exp);
    @(posedge clk);
    {regWr, regRd, regAddr, regWrData} <= {w, r, adr, wd};
    @(posedge clk);
    {regWr, regRd} <= 2'b00;
    #1;
    if (r) chk(regRdData, exp);
  endtask
  // Every variant back to back on carry, positive and negative overflow
  task test_modes();
    logic [31:0] tA [3] = '{32'hFFFF_7FFF, 32'h7FFF_8000, 32'h8000_7FFF};
    logic [31:0] tB [3] = '{32'hFFFF_7FFF, 32'h7FFF_8000, 32'h7FFF_8000};
    logic [31:0] tD [3] = '{32'hFFFF_0000, 32'h7FFF_FFFF, 32'h8000_0000};
    for (int k = 0; k < 32; k++) begin
      for (int i = 0; i < 3; i++) begin
        step(1'b1, hmw_pkg::hmw_op_t'(k[4:0]), tA[i], tB[i], tD[i]);
      end
    end
    step(1'b0, '0, 32'h0, 32'h0, 32'h0);
    $display("modes test done");
  endtask
  // Exception word load, readback, unmapped read, base form keeps flags
  task test_regs();
    reg_io(1'b0, 1'b1, 4'h4, 32'h0, {28'h0, eCr});
    reg_io(1'b0, 1'b1, 4'hC, 32'h0, 32'h0000_0060);
    reg_io(1'b1, 1'b0, 4'h0, 32'h4000_0000, 32'h0);
    {eOv, eSo} = 2'b10;
    reg_io(1'b0, 1'b1, 4'h0, 32'h0, 32'h4000_0000);
    reg_io(1'b0, 1'b1, 4'h8, 32'h0, eRes);
    reg_io(1'b0, 1'b1, 4'h2, 32'h0, 32'h0);
    reg_io(1'b1, 1'b0, 4'hC, 32'h0, 32'h0);
    reg_io(1'b0, 1'b1, 4'hC, 32'h0, 32'h0);
    step(1'b1, '0, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
    step(1'b0, '0, 32'h0, 32'h0, 32'h0);
    $display("register test done");
  endtask
  task give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    #1;
    chk({resValid, cr0Wr, xerWr, overflowFlag, summaryFlag, condFieldZero}, 32'h0);
    test_modes();
    test_regs();
    give_verdict();
  end
endmodule
bind hmw_mac_top hmw_mac_checker chk_i (.clk, .srst, .opValid, .opCtl,
  .resValid, .resData, .cr0Wr, .condFieldZero, .xerWr, .overflowFlag,
  .summaryFlag, .regAddr, .regWr, .regRd, .regRdData);
`default_nettype wire
